// ===== common/wdog_pkg.sv
// package for the watchdog supervisor: states, timing counts, defaults, carriers
// assumes a 250 MHz device clock and a synchronous host interface on plain ports
// Function
// - up-counting timer expires when count reaches duration chosen by 4-bit code
// - refresh-pending flag is set whenever the timer starts counting
// - refresh write while the pending flag is set refreshes and restarts the timer; the flag stays set
// - timer held reset while off; counting waits for host reset release
// - period is two to the power of the code, in milliseconds
// - changing duration code while on resets the timer
// - successful refresh before expiry decrements the expiry counter by one
// - expiry without refresh restarts timer and adds two to expiry counter
// - expiry counter equal to expiry limit starts a watchdog event
// - expiry limit of two or less starts an event on first expiry
// - window mode accepts refresh only in second half; first half is failure
// - enable bit gates timer; changes need secure write when secure mode on
// - standby enable decides standby running; secure write needed when secure
// - host reset output stays released for a whole soft reset
// - soft reset reloads only the listed subset of defaults
// - per regulator keep-config bit chooses default reload or unchanged state
// - sequenced regulators return to default; unsequenced unbypassed ones turn off
// - after outputs settle wait 30 us, return to run, interrupt if unmasked
// - hard reset powers all down and asserts host reset in sequence
// - after power down wait 30 us, full reload, power up unless fail pin low
// - event counter increments per event; reaching limit goes to fail-safe
// - event counter cleared in ST_OFF and by an event-clear write; host should clear it when possible
// - internal events force hard reset; external input follows its reset type
`default_nettype none
package wdog_pkg;
  localparam int CLK_MHZ = 250;
  localparam int TICK_MS_US = 1000;
  localparam int TICK_CYCLES = TICK_MS_US * CLK_MHZ;
  localparam int SETTLE_US = 30;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int TIMER_W = 16;
  localparam logic [3:0] DEF_DURATION_RST = 4'h0;
  localparam logic [2:0] EXPIRE_ADD = 3'h2;
  localparam logic [2:0] EXPIRE_SUB = 3'h1;
  localparam logic [2:0] EXPIRE_FIRST_MAX = 3'h2;
  localparam logic [3:0] EVENT_CLEAR = 4'h0;

  typedef enum {
    ST_OFF,
    ST_PWRUP,
    ST_RUN,
    ST_SOFT,
    ST_SOFT_WAIT,
    ST_HARD_DOWN,
    ST_HARD_WAIT,
    ST_FAILSAFE
  } sup_state_e;

  // watchdog configuration fields reloaded from defaults
  typedef struct packed {
    logic timer_en;
    logic standby_en;
    logic [3:0] duration;
  } wd_cfg_s;
endpackage
`default_nettype wire

// ===== rtl/wdog_delay.sv
// one-shot settle delay: start pulse, done pulse after DLY cycles
// assumes start is a single-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module wdog_delay #(
  parameter int DLY = wdog_pkg::SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic done
);
  localparam int CW = $clog2(DLY + 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic done_nxt;
  if (DLY < 1)
  begin
    $error("delay below one cycle");
  end
  always_comb
  begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (start)
    begin
      cnt_nxt = CW'(DLY);
    end
    else if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == CW'(1));
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      done <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      done <= done_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/wdog_supervisor.sv
// watchdog supervisor: timer, expiry and event counters, soft/hard reset sequencing
// assumes host accesses arrive as synchronous strobes; the power sequencer answers with done pulses
`timescale 1ns/1ps
`default_nettype none
module wdog_supervisor #(
  parameter int NREG = 4,
  parameter int TICK_DIV = wdog_pkg::TICK_CYCLES,
  parameter int SETTLE_DIV = wdog_pkg::SETTLE_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic POWER_ON_REQ,
  input wire logic STANDBY_ACTIVE,
  input wire logic SECURE_MODE,
  input wire logic CFG_WRITE,
  input wire logic CFG_SECURE,
  input wire wdog_pkg::wd_cfg_s CFG_DATA,
  input wire wdog_pkg::wd_cfg_s DEFAULT_CFG,
  input wire logic WINDOWED_REFRESH_SELECT,
  input wire logic [2:0] EXPIRY_LIMIT,
  input wire logic [3:0] EVENT_LIMIT,
  input wire logic REFRESH_WRITE,
  input wire logic EVENT_CLEAR_WRITE,
  input wire logic EXTERNAL_WATCHDOG_INPUT,
  input wire logic EXTERNAL_INPUT_RESET_TYPE,
  input wire logic EXTERNAL_FAIL_PIN_N,
  input wire logic WDOG_INT_MASK,
  input wire logic INT_ACK,
  input wire logic [NREG-1:0] REGULATOR_KEEP_CONFIG,
  input wire logic [NREG-1:0] REGULATOR_IN_SEQ,
  input wire logic POWER_UP_DONE,
  input wire logic POWER_DOWN_DONE,
  input wire logic OUTPUTS_SETTLED,
  output logic HOST_RESET_OUTPUT_N,
  output logic INTERRUPT_OUTPUT_N,
  output logic WATCHDOG_INTERRUPT_FLAG,
  output logic REFRESH_PENDING_FLAG,
  output logic [2:0] EXPIRY_COUNTER,
  output logic [3:0] EVENT_COUNTER,
  output wdog_pkg::wd_cfg_s WD_CFG,
  output logic [NREG-1:0] REGULATOR_RELOAD,
  output logic [NREG-1:0] REGULATOR_OFF,
  output logic SOFT_RELOAD,
  output logic FULL_RELOAD,
  output logic POWER_DOWN_REQ,
  output logic POWER_UP_REQ,
  output logic FAILSAFE
);
  if (NREG < 1)
  begin
    $error("need at least one regulator");
  end

  wdog_pkg::sup_state_e state_r, state_nxt;
  logic [wdog_pkg::TIMER_W-1:0] timer_r, timer_nxt;
  logic pend_r, pend_nxt;
  logic [2:0] exp_r, exp_nxt;
  logic [3:0] evt_r, evt_nxt;
  wdog_pkg::wd_cfg_s cfg_r, cfg_nxt;
  logic rst_out_r, rst_out_nxt;
  logic intf_r, intf_nxt;
  logic [NREG-1:0] reload_r, reload_nxt, off_r, off_nxt;
  logic soft_r, soft_nxt, full_r, full_nxt, pdn_r, pdn_nxt, pup_r, pup_nxt, fs_r, fs_nxt;
  logic tick, settle_start, settle_done, tick_clear;
  logic running, expired, half, wd_event, ext_event;
  logic [wdog_pkg::TIMER_W:0] period;

  wdog_tick #(.DIV(TICK_DIV)) u_tick (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .clear(tick_clear),
    .tick(tick)
  );

  wdog_delay #(.DLY(SETTLE_DIV)) u_settle (
    .clk(CLOCK),
    .rst_n(RESET_N),
    .start(settle_start),
    .done(settle_done)
  );

  // period in ms is two to the code
  assign period = (wdog_pkg::TIMER_W + 1)'(1) << cfg_r.duration;
  assign running = (state_r == wdog_pkg::ST_RUN) && !rst_out_r && cfg_r.timer_en
                   && (!STANDBY_ACTIVE || cfg_r.standby_en);
  assign expired = running && tick && ({1'b0, timer_r} + 1'b1 >= period);
  assign half = ({timer_r, 1'b0} >= period);
  assign ext_event = (state_r == wdog_pkg::ST_RUN) && !EXTERNAL_WATCHDOG_INPUT;

  always_comb
  begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    pend_nxt = pend_r;
    exp_nxt = exp_r;
    evt_nxt = evt_r;
    cfg_nxt = cfg_r;
    rst_out_nxt = rst_out_r;
    intf_nxt = intf_r && !INT_ACK;
    reload_nxt = '0;
    off_nxt = off_r;
    soft_nxt = 1'b0;
    full_nxt = 1'b0;
    pdn_nxt = 1'b0;
    pup_nxt = 1'b0;
    fs_nxt = fs_r;
    settle_start = 1'b0;
    tick_clear = 1'b0;
    wd_event = 1'b0;

    // secured configuration writes
    if (CFG_WRITE && (!SECURE_MODE || CFG_SECURE))
    begin
      cfg_nxt = CFG_DATA;
      if (CFG_DATA.duration != cfg_r.duration && state_r == wdog_pkg::ST_RUN)
      begin
        timer_nxt = '0;
        tick_clear = 1'b1;
        pend_nxt = 1'b1;
      end
    end

    if (EVENT_CLEAR_WRITE)
    begin
      evt_nxt = wdog_pkg::EVENT_CLEAR;
    end

    if (running)
    begin
      if (REFRESH_WRITE && pend_r)
      begin
        timer_nxt = '0;
        tick_clear = 1'b1;
        pend_nxt = 1'b1;
        if (!WINDOWED_REFRESH_SELECT || half)
        begin
          if (exp_r != '0)
          begin
            exp_nxt = exp_r - wdog_pkg::EXPIRE_SUB;
          end
        end
        else
        begin
          exp_nxt = exp_r + wdog_pkg::EXPIRE_ADD;
          wd_event = (EXPIRY_LIMIT <= wdog_pkg::EXPIRE_FIRST_MAX) || (exp_nxt == EXPIRY_LIMIT);
        end
      end
      else if (expired)
      begin
        timer_nxt = '0;
        pend_nxt = 1'b1;
        exp_nxt = exp_r + wdog_pkg::EXPIRE_ADD;
        wd_event = (EXPIRY_LIMIT <= wdog_pkg::EXPIRE_FIRST_MAX)
                   || (exp_nxt == EXPIRY_LIMIT);
      end
      else if (tick)
      begin
        timer_nxt = timer_r + 1'b1;
      end
    end

    unique case (state_r)
      wdog_pkg::ST_OFF:
      begin
        timer_nxt = '0;
        evt_nxt = wdog_pkg::EVENT_CLEAR;
        exp_nxt = '0;
        rst_out_nxt = 1'b1;
        if (POWER_ON_REQ && EXTERNAL_FAIL_PIN_N)
        begin
          pup_nxt = 1'b1;
          state_nxt = wdog_pkg::ST_PWRUP;
        end
      end
      wdog_pkg::ST_PWRUP:
      begin
        if (POWER_UP_DONE)
        begin
          rst_out_nxt = 1'b0;
          off_nxt = '0;
          timer_nxt = '0;
          tick_clear = 1'b1;
          pend_nxt = 1'b1;
          state_nxt = wdog_pkg::ST_RUN;
        end
      end
      wdog_pkg::ST_RUN:
      begin
        if (wd_event || ext_event)
        begin
          evt_nxt = evt_r + 1'b1;
          timer_nxt = '0;
          if (evt_r + 1'b1 == EVENT_LIMIT)
          begin
            fs_nxt = 1'b1;
            pdn_nxt = 1'b1;
            state_nxt = wdog_pkg::ST_FAILSAFE;
          end
          else if (ext_event && !wd_event && !EXTERNAL_INPUT_RESET_TYPE)
          begin
            soft_nxt = 1'b1;
            cfg_nxt = DEFAULT_CFG;
            reload_nxt = ~REGULATOR_KEEP_CONFIG & REGULATOR_IN_SEQ;
            off_nxt = ~REGULATOR_KEEP_CONFIG & ~REGULATOR_IN_SEQ;
            state_nxt = wdog_pkg::ST_SOFT;
          end
          else
          begin
            pdn_nxt = 1'b1;
            state_nxt = wdog_pkg::ST_HARD_DOWN;
          end
        end
      end
      wdog_pkg::ST_SOFT:
      begin
        rst_out_nxt = 1'b0;
        if (OUTPUTS_SETTLED)
        begin
          settle_start = 1'b1;
          state_nxt = wdog_pkg::ST_SOFT_WAIT;
        end
      end
      wdog_pkg::ST_SOFT_WAIT:
      begin
        rst_out_nxt = 1'b0;
        if (settle_done)
        begin
          intf_nxt = 1'b1;
          timer_nxt = '0;
          tick_clear = 1'b1;
          pend_nxt = 1'b1;
          state_nxt = wdog_pkg::ST_RUN;
        end
      end
      wdog_pkg::ST_HARD_DOWN:
      begin
        rst_out_nxt = 1'b1;
        off_nxt = '1;
        if (POWER_DOWN_DONE)
        begin
          settle_start = 1'b1;
          state_nxt = wdog_pkg::ST_HARD_WAIT;
        end
      end
      wdog_pkg::ST_HARD_WAIT:
      begin
        if (settle_done)
        begin
          full_nxt = 1'b1;
          cfg_nxt = DEFAULT_CFG;
          exp_nxt = '0;
          state_nxt = wdog_pkg::ST_OFF;
        end
      end
      wdog_pkg::ST_FAILSAFE:
      begin
        rst_out_nxt = 1'b1;
        off_nxt = '1;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state_r <= wdog_pkg::ST_OFF;
      timer_r <= '0;
      pend_r <= 1'b0;
      exp_r <= '0;
      evt_r <= wdog_pkg::EVENT_CLEAR;
      cfg_r <= '{timer_en: 1'b0, standby_en: 1'b0, duration: wdog_pkg::DEF_DURATION_RST};
      rst_out_r <= 1'b1;
      intf_r <= 1'b0;
      reload_r <= '0;
      off_r <= '1;
      soft_r <= 1'b0;
      full_r <= 1'b0;
      pdn_r <= 1'b0;
      pup_r <= 1'b0;
      fs_r <= 1'b0;
      INTERRUPT_OUTPUT_N <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
      pend_r <= pend_nxt;
      exp_r <= exp_nxt;
      evt_r <= evt_nxt;
      cfg_r <= cfg_nxt;
      rst_out_r <= rst_out_nxt;
      intf_r <= intf_nxt;
      reload_r <= reload_nxt;
      off_r <= off_nxt;
      soft_r <= soft_nxt;
      full_r <= full_nxt;
      pdn_r <= pdn_nxt;
      pup_r <= pup_nxt;
      fs_r <= fs_nxt;
      INTERRUPT_OUTPUT_N <= !(intf_nxt && !WDOG_INT_MASK);
    end
  end

  assign HOST_RESET_OUTPUT_N = !rst_out_r;
  assign WATCHDOG_INTERRUPT_FLAG = intf_r;
  assign REFRESH_PENDING_FLAG = pend_r;
  assign EXPIRY_COUNTER = exp_r;
  assign EVENT_COUNTER = evt_r;
  assign WD_CFG = cfg_r;
  assign REGULATOR_RELOAD = reload_r;
  assign REGULATOR_OFF = off_r;
  assign SOFT_RELOAD = soft_r;
  assign FULL_RELOAD = full_r;
  assign POWER_DOWN_REQ = pdn_r;
  assign POWER_UP_REQ = pup_r;
  assign FAILSAFE = fs_r;
endmodule
`default_nettype wire

// ===== rtl/wdog_tick.sv
// 1 ms time base divider
// assumes CLOCK at the package rate; clear restarts the phase
`timescale 1ns/1ps
`default_nettype none
module wdog_tick #(
  parameter int DIV = wdog_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_nxt;
  if (DIV < 2)
  begin
    $error("tick divider below 2");
  end
  always_comb
  begin
    tick_nxt = 1'b0;
    cnt_nxt = cnt_r + 1'b1;
    if (clear)
    begin
      cnt_nxt = '0;
    end
    else if (cnt_r == CW'(DIV - 1))
    begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== test/pmic_watchdog_supervisor_tb.sv
// self-checking bench for the watchdog supervisor with a sequencer model
// assumes shortened tick and settle counts
`timescale 1ns/1ps
`default_nettype none
module pmic_watchdog_supervisor_tb;
  localparam int NREG = 3;
  logic CLOCK = 0, RESET_N = 0, POWER_ON_REQ = 0, STANDBY_ACTIVE = 0, SECURE_MODE = 1, CFG_WRITE = 0;
  logic CFG_SECURE = 0, REFRESH_WRITE = 0, EVENT_CLEAR_WRITE = 0, EXTERNAL_WATCHDOG_INPUT = 1, INT_ACK = 0;
  logic EXTERNAL_INPUT_RESET_TYPE = 0, EXTERNAL_FAIL_PIN_N = 1, WDOG_INT_MASK = 0, WINDOWED_REFRESH_SELECT = 0;
  logic [2:0] EXPIRY_LIMIT = 3'h7;
  logic [3:0] EVENT_LIMIT = 4'h2;
  logic [NREG-1:0] REGULATOR_KEEP_CONFIG = 3'h1, REGULATOR_IN_SEQ = 3'h3;
  wdog_pkg::wd_cfg_s CFG_DATA = '0, DEFAULT_CFG = 6'h19;
  logic POWER_UP_DONE, POWER_DOWN_DONE, OUTPUTS_SETTLED, HOST_RESET_OUTPUT_N, INTERRUPT_OUTPUT_N, FAILSAFE;
  logic WATCHDOG_INTERRUPT_FLAG, REFRESH_PENDING_FLAG, SOFT_RELOAD, FULL_RELOAD, POWER_DOWN_REQ, POWER_UP_REQ;
  logic [2:0] EXPIRY_COUNTER;
  logic [3:0] EVENT_COUNTER;
  logic [NREG-1:0] REGULATOR_RELOAD, REGULATOR_OFF;
  wdog_pkg::wd_cfg_s WD_CFG;
  int n_errors = 0, n_checks = 0, cycles = 0;

  wdog_supervisor #(.NREG(NREG), .TICK_DIV(4), .SETTLE_DIV(3)) dut (
    .CLOCK(CLOCK), .RESET_N(RESET_N), .POWER_ON_REQ(POWER_ON_REQ), .STANDBY_ACTIVE(STANDBY_ACTIVE),
    .SECURE_MODE(SECURE_MODE), .CFG_WRITE(CFG_WRITE), .CFG_SECURE(CFG_SECURE), .CFG_DATA(CFG_DATA),
    .DEFAULT_CFG(DEFAULT_CFG), .WINDOWED_REFRESH_SELECT(WINDOWED_REFRESH_SELECT), .EXPIRY_LIMIT(EXPIRY_LIMIT),
    .EVENT_LIMIT(EVENT_LIMIT), .REFRESH_WRITE(REFRESH_WRITE), .EVENT_CLEAR_WRITE(EVENT_CLEAR_WRITE),
    .EXTERNAL_WATCHDOG_INPUT(EXTERNAL_WATCHDOG_INPUT), .EXTERNAL_INPUT_RESET_TYPE(EXTERNAL_INPUT_RESET_TYPE),
    .EXTERNAL_FAIL_PIN_N(EXTERNAL_FAIL_PIN_N), .WDOG_INT_MASK(WDOG_INT_MASK), .INT_ACK(INT_ACK),
    .REGULATOR_KEEP_CONFIG(REGULATOR_KEEP_CONFIG), .REGULATOR_IN_SEQ(REGULATOR_IN_SEQ),
    .POWER_UP_DONE(POWER_UP_DONE), .POWER_DOWN_DONE(POWER_DOWN_DONE), .OUTPUTS_SETTLED(OUTPUTS_SETTLED),
    .HOST_RESET_OUTPUT_N(HOST_RESET_OUTPUT_N), .INTERRUPT_OUTPUT_N(INTERRUPT_OUTPUT_N),
    .WATCHDOG_INTERRUPT_FLAG(WATCHDOG_INTERRUPT_FLAG), .REFRESH_PENDING_FLAG(REFRESH_PENDING_FLAG),
    .EXPIRY_COUNTER(EXPIRY_COUNTER), .EVENT_COUNTER(EVENT_COUNTER), .WD_CFG(WD_CFG),
    .REGULATOR_RELOAD(REGULATOR_RELOAD), .REGULATOR_OFF(REGULATOR_OFF), .SOFT_RELOAD(SOFT_RELOAD),
    .FULL_RELOAD(FULL_RELOAD), .POWER_DOWN_REQ(POWER_DOWN_REQ), .POWER_UP_REQ(POWER_UP_REQ), .FAILSAFE(FAILSAFE));
  wdog_seq_model #(.DLY(4)) seq (.clk(CLOCK), .up_req(POWER_UP_REQ), .down_req(POWER_DOWN_REQ),
    .soft_req(SOFT_RELOAD), .up_done(POWER_UP_DONE), .down_done(POWER_DOWN_DONE), .settled(OUTPUTS_SETTLED));

  initial
    forever #2 CLOCK = ~CLOCK;

  always @(posedge CLOCK)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      n_errors++;
      summarize;
    end
  end

  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task cfg_wr(input logic sec, input wdog_pkg::wd_cfg_s d);
    CFG_SECURE <= sec;
    CFG_DATA <= d;
    CFG_WRITE <= 1;
    @(posedge CLOCK);
    CFG_WRITE <= 0;
    repeat (2) @(posedge CLOCK);
  endtask

  task refresh;
    REFRESH_WRITE <= 1;
    @(posedge CLOCK);
    REFRESH_WRITE <= 0;
    repeat (2) @(posedge CLOCK);
  endtask

  task ext_event(input logic hard);
    EXTERNAL_INPUT_RESET_TYPE <= hard;
    EXTERNAL_WATCHDOG_INPUT <= 0;
    @(posedge CLOCK);
    EXTERNAL_WATCHDOG_INPUT <= 1;
  endtask

  task t_power_up;
    wdog_pkg::wd_cfg_s old;
    POWER_ON_REQ <= 1;
    for (int i = 0; i < 100 && HOST_RESET_OUTPUT_N !== 1'b1; i++) @(posedge CLOCK);
    @(posedge CLOCK);
    chk("pending", REFRESH_PENDING_FLAG, 1);
    old = WD_CFG;
    cfg_wr(0, 6'h35);
    chk("plain write", WD_CFG, old);
    cfg_wr(1, 6'h22);
    chk("secure write", WD_CFG, 6'h22);
    SECURE_MODE <= 0;
    cfg_wr(0, 6'h23);
    chk("open write", WD_CFG, 6'h23);
    SECURE_MODE <= 1;
    $display("power-up test done");
  endtask

  task t_refresh;
    int n;
    for (n = 0; n < 200 && EXPIRY_COUNTER !== 3'h2; n++) @(posedge CLOCK);
    chk("first expiry", EXPIRY_COUNTER, 2);
    chk("period", n >= 24 && n <= 44, 1);
    refresh;
    chk("refresh", EXPIRY_COUNTER, 1);
    WINDOWED_REFRESH_SELECT <= 1;
    refresh;
    chk("early refresh", EXPIRY_COUNTER, 3);
    repeat (22) @(posedge CLOCK);
    refresh;
    chk("late refresh", EXPIRY_COUNTER, 2);
    WINDOWED_REFRESH_SELECT <= 0;
    STANDBY_ACTIVE <= 1;
    repeat (40) @(posedge CLOCK);
    chk("standby hold", EXPIRY_COUNTER, 2);
    STANDBY_ACTIVE <= 0;
    $display("refresh test done");
  endtask

  task t_hard;
    EXPIRY_LIMIT <= 3'h2;
    EXTERNAL_FAIL_PIN_N <= 0;
    for (int i = 0; i < 100 && HOST_RESET_OUTPUT_N !== 1'b0; i++) @(posedge CLOCK);
    chk("host reset", HOST_RESET_OUTPUT_N, 0);
    chk("event count", EVENT_COUNTER, 1);
    for (int i = 0; i < 100 && FULL_RELOAD !== 1'b1; i++) @(posedge CLOCK);
    chk("full reload", FULL_RELOAD, 1);
    repeat (20) @(posedge CLOCK);
    chk("fail pin hold", HOST_RESET_OUTPUT_N, 0);
    chk("event cleared", EVENT_COUNTER, 0);
    chk("reload cfg", WD_CFG, DEFAULT_CFG);
    $display("hard reset test done");
  endtask

  task t_soft;
    logic [NREG-1:0] rl;
    logic hs;
    rl = '0;
    hs = 1;
    EXTERNAL_FAIL_PIN_N <= 1;
    EXPIRY_LIMIT <= 3'h7;
    for (int i = 0; i < 100 && HOST_RESET_OUTPUT_N !== 1'b1; i++) @(posedge CLOCK);
    cfg_wr(1, 6'h2c);
    ext_event(0);
    for (int i = 0; i < 100 && INTERRUPT_OUTPUT_N !== 1'b0; i++)
    begin
      rl |= REGULATOR_RELOAD;
      hs &= HOST_RESET_OUTPUT_N;
      @(posedge CLOCK);
    end
    chk("interrupt", INTERRUPT_OUTPUT_N, 0);
    chk("host kept", hs, 1);
    chk("reloaded", rl, 3'h2);
    chk("regs off", REGULATOR_OFF, 3'h4);
    chk("soft cfg", WD_CFG, DEFAULT_CFG);
    chk("event count", EVENT_COUNTER, 1);
    INT_ACK <= 1;
    @(posedge CLOCK);
    INT_ACK <= 0;
    repeat (2) @(posedge CLOCK);
    chk("flag ack", WATCHDOG_INTERRUPT_FLAG, 0);
    $display("soft reset test done");
  endtask

  task t_failsafe;
    EVENT_CLEAR_WRITE <= 1;
    @(posedge CLOCK);
    EVENT_CLEAR_WRITE <= 0;
    WDOG_INT_MASK <= 1;
    repeat (2) @(posedge CLOCK);
    chk("event clear", EVENT_COUNTER, 0);
    ext_event(0);
    for (int i = 0; i < 50 && WATCHDOG_INTERRUPT_FLAG !== 1'b1; i++) @(posedge CLOCK);
    chk("soft flag", WATCHDOG_INTERRUPT_FLAG, 1);
    chk("masked", INTERRUPT_OUTPUT_N, 1);
    ext_event(1);
    for (int i = 0; i < 50 && FAILSAFE !== 1'b1; i++) @(posedge CLOCK);
    chk("failsafe", FAILSAFE, 1);
    chk("event count", EVENT_COUNTER, 2);
    $display("fail-safe test done");
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge CLOCK);
    RESET_N <= 1;
    t_power_up;
    t_refresh;
    t_hard;
    t_soft;
    t_failsafe;
    summarize;
  end
endmodule

bind wdog_supervisor wdog_supervisor_properties #(.NREG(NREG)) chk_props (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .REFRESH_WRITE(REFRESH_WRITE), .REFRESH_PENDING_FLAG(REFRESH_PENDING_FLAG),
  .WINDOWED_REFRESH_SELECT(WINDOWED_REFRESH_SELECT), .WD_CFG(WD_CFG), .EXPIRY_COUNTER(EXPIRY_COUNTER),
  .EVENT_COUNTER(EVENT_COUNTER), .EVENT_LIMIT(EVENT_LIMIT), .HOST_RESET_OUTPUT_N(HOST_RESET_OUTPUT_N),
  .INTERRUPT_OUTPUT_N(INTERRUPT_OUTPUT_N), .WDOG_INT_MASK(WDOG_INT_MASK), .SOFT_RELOAD(SOFT_RELOAD),
  .FULL_RELOAD(FULL_RELOAD), .POWER_DOWN_REQ(POWER_DOWN_REQ), .POWER_DOWN_DONE(POWER_DOWN_DONE),
  .FAILSAFE(FAILSAFE), .REGULATOR_RELOAD(REGULATOR_RELOAD), .REGULATOR_KEEP_CONFIG(REGULATOR_KEEP_CONFIG));
`default_nettype wire

// ===== test/wdog_seq_model.sv
// power sequencer model: answers each request pulse after DLY cycles
// assumes one-cycle request pulses
`timescale 1ns/1ps
`default_nettype none
module wdog_seq_model #(
  parameter int DLY = 4
) (
  input wire logic clk,
  input wire logic up_req,
  input wire logic down_req,
  input wire logic soft_req,
  output logic up_done,
  output logic down_done,
  output logic settled
);
  logic [7:0] up_r = '0;
  logic [7:0] dn_r = '0;
  logic [7:0] sf_r = '0;
  always @(posedge clk)
  begin
    up_r <= {up_r[6:0], up_req};
    dn_r <= {dn_r[6:0], down_req};
    sf_r <= {sf_r[6:0], soft_req};
  end
  assign up_done = up_r[DLY-1];
  assign down_done = dn_r[DLY-1];
  assign settled = sf_r[DLY-1];
endmodule
`default_nettype wire

// ===== test/wdog_supervisor_properties.sv
// port checker for the watchdog supervisor
// assumes the bench's short tick and settle counts
`timescale 1ns/1ps
`default_nettype none
module wdog_supervisor_properties #(
  parameter int NREG = 4
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic REFRESH_WRITE,
  input wire logic REFRESH_PENDING_FLAG,
  input wire logic WINDOWED_REFRESH_SELECT,
  input wire wdog_pkg::wd_cfg_s WD_CFG,
  input wire logic [2:0] EXPIRY_COUNTER,
  input wire logic [3:0] EVENT_COUNTER,
  input wire logic [3:0] EVENT_LIMIT,
  input wire logic HOST_RESET_OUTPUT_N,
  input wire logic INTERRUPT_OUTPUT_N,
  input wire logic WDOG_INT_MASK,
  input wire logic SOFT_RELOAD,
  input wire logic FULL_RELOAD,
  input wire logic POWER_DOWN_REQ,
  input wire logic POWER_DOWN_DONE,
  input wire logic FAILSAFE,
  input wire logic [NREG-1:0] REGULATOR_RELOAD,
  input wire logic [NREG-1:0] REGULATOR_KEEP_CONFIG
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  a_pending_at_start: assert property ($rose(HOST_RESET_OUTPUT_N) |-> ##[0:2] REFRESH_PENDING_FLAG)
    else $error("pending flag not set at timer start");
  a_refresh_decrement: assert property (REFRESH_WRITE && REFRESH_PENDING_FLAG && HOST_RESET_OUTPUT_N
    && WD_CFG.timer_en && !WINDOWED_REFRESH_SELECT && EXPIRY_COUNTER != 3'h0 && !SOFT_RELOAD
    |=> EXPIRY_COUNTER == $past(EXPIRY_COUNTER) - 3'h1)
    else $error("refresh did not lower expiry count by one");
  a_event_counted: assert property ((POWER_DOWN_REQ || SOFT_RELOAD) |-> ##[0:2] EVENT_COUNTER != 4'h0)
    else $error("reset started without counted event");
  a_event_limit: assert property (EVENT_COUNTER == EVENT_LIMIT && EVENT_COUNTER != 4'h0 |-> ##[0:3] FAILSAFE)
    else $error("event limit reached without fail-safe");
  a_failsafe_sticky: assert property (FAILSAFE |=> FAILSAFE)
    else $error("fail-safe left without reset");
  a_soft_host_kept: assert property ($rose(SOFT_RELOAD) |-> HOST_RESET_OUTPUT_N [*8])
    else $error("host reset asserted in soft reset");
  a_int_unmasked: assert property (!INTERRUPT_OUTPUT_N |-> !$past(WDOG_INT_MASK))
    else $error("interrupt asserted while masked");
  a_keep_config: assert property (|REGULATOR_RELOAD |-> (REGULATOR_RELOAD & REGULATOR_KEEP_CONFIG) == '0)
    else $error("kept regulator was reloaded");
  a_full_reload_wait: assert property (FULL_RELOAD |-> !HOST_RESET_OUTPUT_N && !$past(POWER_DOWN_DONE))
    else $error("full reload without settle wait");
  a_off_holds_count: assert property (!HOST_RESET_OUTPUT_N |=> EXPIRY_COUNTER <= $past(EXPIRY_COUNTER))
    else $error("expiry count grew while host held in reset");
endmodule
`default_nettype wire
